// file: hdl/uab_remote_node.sv
/*
  Remote node on the serial link: sends bytes or wake breaks, receives bytes.
  Assumes the user sets bitCycles to the link's bit time in core_clk cycles.
*/
`include "uab_cfg.svh"

module uab_remote_node (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [23:0] bitCycles,
  input  wire logic        sendValid,
  input  wire logic        sendBreak,
  input  wire logic [7:0]  sendData,
  output logic             sendReady,
  output logic             rcvValid,
  output logic      [7:0]  rcvData,
  output logic             rcvFramingErr,
  uab_link_if.node         link
);

  // ------------------------------------------------------------
  // Transmit: byte frame or long all-zero wake character
  // ------------------------------------------------------------
  logic        txActive_r;
  logic [15:0] txShift_r;
  logic [4:0]  txLeft_r;
  logic [23:0] txCnt_r;

  assign sendReady   = ~txActive_r;
  assign link.nodeTx = txActive_r ? txShift_r[0] : 1'b1;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txActive_r <= 1'b0;
      txShift_r  <= 16'hFFFF;
      txLeft_r   <= 5'h0;
      txCnt_r    <= 24'h0;
    end else if (ce) begin
      if (!txActive_r && sendValid) begin
        txActive_r <= 1'b1;
        txCnt_r    <= bitCycles - 24'h1;
        if (sendBreak) begin // see RL16
          txShift_r <= 16'hE000;
          txLeft_r  <= `UAB_NODE_ZEROS + 5'h1;
        end else begin
          txShift_r <= {7'h7F, sendData, 1'b0};
          txLeft_r  <= 5'(`UAB_FRAME_BITS);
        end
      end else if (txActive_r) begin
        if (txCnt_r == 24'h0) begin
          txShift_r <= {1'b1, txShift_r[15:1]};
          txLeft_r  <= txLeft_r - 5'h1;
          txCnt_r   <= bitCycles - 24'h1;
          if (txLeft_r == 5'h1) txActive_r <= 1'b0;
        end else begin
          txCnt_r <= txCnt_r - 24'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Receive
  // ------------------------------------------------------------
  logic rxMeta_r, rxSync_r, rxPrev_r;
  uab_pkg::uab_rx_state_t rxState_r;
  logic [23:0] rxCnt_r;
  logic [2:0]  rxBit_r;
  logic [7:0]  rxShift_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end else if (ce) begin
      rxMeta_r <= link.unitTx;
      rxSync_r <= rxMeta_r;
      rxPrev_r <= rxSync_r;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxState_r     <= uab_pkg::UAB_RX_IDLE;
      rxCnt_r       <= 24'h0;
      rxBit_r       <= 3'h0;
      rxShift_r     <= 8'h00;
      rcvValid      <= 1'b0;
      rcvData       <= 8'h00;
      rcvFramingErr <= 1'b0;
    end else if (ce) begin
      rcvValid <= 1'b0;
      if (rxCnt_r != 24'h0) rxCnt_r <= rxCnt_r - 24'h1;
      case (rxState_r)
        uab_pkg::UAB_RX_IDLE: begin
          if (rxPrev_r && !rxSync_r) begin
            rxState_r <= uab_pkg::UAB_RX_START;
            rxCnt_r   <= bitCycles >> 1;
          end
        end
        uab_pkg::UAB_RX_START: begin
          if (rxCnt_r == 24'h0) begin
            rxState_r <= rxSync_r ? uab_pkg::UAB_RX_IDLE : uab_pkg::UAB_RX_DATA;
            rxCnt_r   <= bitCycles - 24'h1;
            rxBit_r   <= 3'h0;
          end
        end
        uab_pkg::UAB_RX_DATA: begin
          if (rxCnt_r == 24'h0) begin
            rxShift_r <= {rxSync_r, rxShift_r[7:1]};
            rxBit_r   <= rxBit_r + 3'h1;
            rxCnt_r   <= bitCycles - 24'h1;
            if (rxBit_r == 3'h7) rxState_r <= uab_pkg::UAB_RX_STOP;
          end
        end
        uab_pkg::UAB_RX_STOP: begin
          if (rxCnt_r == 24'h0) begin
            rcvValid      <= 1'b1;
            rcvData       <= rxShift_r;
            rcvFramingErr <= ~rxSync_r;
            rxState_r     <= rxSync_r ? uab_pkg::UAB_RX_IDLE : uab_pkg::UAB_RX_HOLD;
          end
        end
        uab_pkg::UAB_RX_HOLD: begin
          if (rxSync_r) rxState_r <= uab_pkg::UAB_RX_IDLE;
        end
        default: rxState_r <= uab_pkg::UAB_RX_IDLE;
      endcase
    end
  end

endmodule : uab_remote_node

// file: hdl/uab_serial_unit.sv
/*
  Serial unit with baud measurement, wake on break and break transmit.
  Assumes an Avalon-MM master on core_clk and a remote node on the link.
*/
// Implementation choices: the register addresses and the Avalon-MM register port.
// What this block does
// RL1: Autobaud enable starts measurement, receiver held idle
// RL2: Count from first rise after start bit
// RL3: Fifth rise: keep count, clear enable, flag
// RL4: Reading receive data clears receive flag
// RL5: Divisor pair is one 16-bit counter
// RL6: Counter ticks at base clock over eight
// RL7: Counter starts at one; software subtracts one
// RL8: Software checks high divisor zero for overflow
// RL9: With wake enabled, measure byte after break
// RL10: Wake enable suppresses reception, watches line
// RL11: Falling edge under wake sets receive flag
// RL12: Wake interrupt clocked awake, asynchronous asleep
// RL13: Rising edge ending break clears wake enable
// RL14: Receive data read clears wake interrupt
// RL15: Non-zero char: first low is wake
// RL16: Remote wake character zeros, thirteen bits
// RL17: Software checks receiver idle before wake enable
// RL18: Break: start, twelve zeros, stop bit
// RL19: Data write with break request sends break
// RL20: Break request cleared after stop; next byte follows
// RL21: Shift-empty status covers breaks too
// RL22: Received break: flag, framing error, zero data
`include "uab_cfg.svh"

module uab_serial_unit (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        sleepMode,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             rxEventIrq,
  uab_link_if.unit         link
);

  // ------------------------------------------------------------
  // Bus slave: one wait cycle, then the access is taken
  // ------------------------------------------------------------
  logic        ack_r;
  logic        wrEn;
  logic        rdEn;
  logic [31:0] rdMux;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wrEn            = avs_write & ack_r;
  assign rdEn            = avs_read & ack_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // ------------------------------------------------------------
  // Line synchroniser and edges
  // ------------------------------------------------------------
  logic rxMeta_r, rxSync_r, rxPrev_r;
  logic rxFall, rxRise;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end else if (ce) begin
      rxMeta_r <= link.nodeTx;
      rxSync_r <= rxMeta_r;
      rxPrev_r <= rxSync_r;
    end
  end

  assign rxFall = rxPrev_r & ~rxSync_r;
  assign rxRise = ~rxPrev_r & rxSync_r;

  // ------------------------------------------------------------
  // Control bits and divisor
  // ------------------------------------------------------------
  logic        abEn_r, wobe_r, wide_r, hs_r, send_break_request_r, transmit_enable_r;
  logic [7:0]  divLo_r, divHi_r;
  logic [7:0]  preScale;
  logic [23:0] bitCycles;
  logic [11:0] abdCycles;
  logic        abdDone, wakeEnd, breakDone;

  always_comb begin
    case ({wide_r, hs_r})
      2'b00:   preScale = `UAB_PRE_SLOW;
      2'b11:   preScale = `UAB_PRE_FAST;
      default: preScale = `UAB_PRE_MID;
    endcase
  end

  assign bitCycles = 24'(preScale) * (24'(wide_r ? divHi_r : 8'h00) * 24'h100 + 24'(divLo_r) + 24'h1);
  assign abdCycles = 12'(preScale) * 12'(`UAB_ABD_RATIO); // see RL6

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      abEn_r  <= 1'b0;
      wobe_r  <= 1'b0;
      wide_r  <= 1'b0;
      hs_r    <= 1'b0;
      send_break_request_r <= 1'b0;
      transmit_enable_r  <= 1'b0;
    end else if (ce) begin
      if (abdDone) abEn_r <= 1'b0; // see RL3
      if (wakeEnd) wobe_r <= 1'b0; // see RL13
      if (breakDone) send_break_request_r <= 1'b0; // see RL20
      if (wrEn && avs_address == `UAB_OFS_BAUD_CONTROL_REG) begin
        abEn_r <= avs_writedata[`UAB_BIT_ABEN];
        wobe_r <= avs_writedata[`UAB_BIT_WOBE];
        wide_r <= avs_writedata[`UAB_BIT_WIDE];
      end
      if (wrEn && avs_address == `UAB_OFS_TXSTAT) begin
        hs_r    <= avs_writedata[`UAB_BIT_HS];
        send_break_request_r <= avs_writedata[`UAB_BIT_SEND_BREAK_REQUEST];
        transmit_enable_r  <= avs_writedata[`UAB_BIT_TRANSMIT_ENABLE];
      end
    end
  end

  // ------------------------------------------------------------
  // Baud measurement on the sync byte
  // ------------------------------------------------------------
  uab_pkg::uab_ab_state_t abState_r;
  logic [11:0] abPre_r;
  logic [2:0]  abRises_r;

  assign abdDone = (abState_r == uab_pkg::UAB_AB_COUNT) && rxRise && (abRises_r == `UAB_ABD_RISES);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      abState_r <= uab_pkg::UAB_AB_OFF;
      abPre_r   <= 12'h000;
      abRises_r <= 3'h0;
      divLo_r   <= `UAB_RST_DIV;
      divHi_r   <= `UAB_RST_DIV;
    end else if (ce) begin
      if (wrEn && avs_address == `UAB_OFS_DIVLO) divLo_r <= avs_writedata[7:0];
      if (wrEn && avs_address == `UAB_OFS_DIVHI) divHi_r <= avs_writedata[7:0];
      case (abState_r)
        uab_pkg::UAB_AB_OFF: begin
          if (abEn_r && !wobe_r) abState_r <= uab_pkg::UAB_AB_WSTART; // see RL9
        end
        uab_pkg::UAB_AB_WSTART: begin
          if (rxFall) abState_r <= uab_pkg::UAB_AB_WRISE;
        end
        uab_pkg::UAB_AB_WRISE: begin
          if (rxRise) begin // see RL2
            {divHi_r, divLo_r} <= `UAB_ABD_START; // see RL7
            abPre_r   <= 12'h000;
            abRises_r <= 3'h1;
            abState_r <= uab_pkg::UAB_AB_COUNT;
          end
        end
        uab_pkg::UAB_AB_COUNT: begin
          if (rxRise) begin
            abRises_r <= abRises_r + 3'h1;
            if (abdDone) abState_r <= uab_pkg::UAB_AB_OFF; // see RL3
          end
          if (abPre_r == abdCycles - 12'h001) begin
            abPre_r            <= 12'h000;
            {divHi_r, divLo_r} <= {divHi_r, divLo_r} + 16'h0001; // see RL5
          end else begin
            abPre_r <= abPre_r + 12'h001;
          end
        end
        default: abState_r <= uab_pkg::UAB_AB_OFF;
      endcase
      // Software may abort a measurement by clearing the enable
      if (!abEn_r) abState_r <= uab_pkg::UAB_AB_OFF;
    end
  end

  // ------------------------------------------------------------
  // Wake on break
  // ------------------------------------------------------------
  logic wakeSeen_r;
  logic wakeFall;

  assign wakeFall = wobe_r && rxFall; // see RL11
  assign wakeEnd  = wobe_r && wakeSeen_r && rxRise; // see RL15

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wakeSeen_r <= 1'b0;
    end else if (ce) begin
      if (!wobe_r) wakeSeen_r <= 1'b0;
      else if (rxFall) wakeSeen_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  uab_pkg::uab_rx_state_t rxState_r;
  logic [23:0] rxCnt_r;
  logic [2:0]  rxBit_r;
  logic [7:0]  rxShift_r, rxData_r;
  logic        framing_error_r, rxFlag_r, rxDone;

  assign rxDone = (rxState_r == uab_pkg::UAB_RX_STOP) && (rxCnt_r == 24'h0);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxState_r <= uab_pkg::UAB_RX_IDLE;
      rxCnt_r   <= 24'h0;
      rxBit_r   <= 3'h0;
      rxShift_r <= 8'h00;
      rxData_r  <= 8'h00;
      framing_error_r    <= 1'b0;
    end else if (ce) begin
      if (rxCnt_r != 24'h0) rxCnt_r <= rxCnt_r - 24'h1;
      case (rxState_r)
        uab_pkg::UAB_RX_IDLE: begin
          if (!wobe_r && !abEn_r && rxFall) begin // see RL1 see RL10
            rxState_r <= uab_pkg::UAB_RX_START;
            rxCnt_r   <= bitCycles >> 1;
          end
        end
        uab_pkg::UAB_RX_START: begin
          if (rxCnt_r == 24'h0) begin
            rxState_r <= rxSync_r ? uab_pkg::UAB_RX_IDLE : uab_pkg::UAB_RX_DATA;
            rxCnt_r   <= bitCycles - 24'h1;
            rxBit_r   <= 3'h0;
          end
        end
        uab_pkg::UAB_RX_DATA: begin
          if (rxCnt_r == 24'h0) begin
            rxShift_r <= {rxSync_r, rxShift_r[7:1]};
            rxBit_r   <= rxBit_r + 3'h1;
            rxCnt_r   <= bitCycles - 24'h1;
            if (rxBit_r == 3'h7) rxState_r <= uab_pkg::UAB_RX_STOP;
          end
        end
        uab_pkg::UAB_RX_STOP: begin
          if (rxCnt_r == 24'h0) begin
            rxData_r  <= rxShift_r; // see RL22
            framing_error_r    <= ~rxSync_r;
            rxState_r <= rxSync_r ? uab_pkg::UAB_RX_IDLE : uab_pkg::UAB_RX_HOLD;
          end
        end
        uab_pkg::UAB_RX_HOLD: begin
          // A break keeps the line low; do not restart until it rises
          if (rxSync_r) rxState_r <= uab_pkg::UAB_RX_IDLE;
        end
        default: rxState_r <= uab_pkg::UAB_RX_IDLE;
      endcase
    end
  end

  // Set wins over the read that clears
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxFlag_r <= 1'b0;
    end else if (ce) begin
      if (rdEn && avs_address == `UAB_OFS_RXDATA) rxFlag_r <= 1'b0; // see RL4 see RL14
      if (rxDone || abdDone || wakeFall) rxFlag_r <= 1'b1; // see RL3 see RL11
    end
  end

  // Asleep the clock may stop, so the line itself raises the request
  assign rxEventIrq = rxFlag_r | (sleepMode & wobe_r & ~link.nodeTx); // see RL12

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  logic [7:0]  txBuf_r;
  logic        txFull_r, txActive_r, txBrk_r, txLoad, txEnd;
  logic [13:0] txShift_r;
  logic [3:0]  txLeft_r;
  logic [23:0] txCnt_r;

  assign txLoad    = !txActive_r && txFull_r && transmit_enable_r;
  assign txEnd     = txActive_r && (txCnt_r == 24'h0) && (txLeft_r == 4'h1);
  assign breakDone = txEnd && txBrk_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txBuf_r  <= 8'h00;
      txFull_r <= 1'b0;
    end else if (ce) begin
      if (txLoad) txFull_r <= 1'b0;
      if (wrEn && avs_address == `UAB_OFS_TXDATA) begin
        txBuf_r  <= avs_writedata[7:0];
        txFull_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txActive_r <= 1'b0;
      txBrk_r    <= 1'b0;
      txShift_r  <= 14'h3FFF;
      txLeft_r   <= 4'h0;
      txCnt_r    <= 24'h0;
    end else if (ce) begin
      if (txLoad) begin
        txActive_r <= 1'b1;
        txBrk_r    <= send_break_request_r;
        txCnt_r    <= bitCycles - 24'h1;
        if (send_break_request_r) begin // see RL19
          txShift_r <= 14'h2000; // see RL18
          txLeft_r  <= `UAB_BREAK_ZEROS + 4'h2;
        end else begin
          txShift_r <= {5'h1F, txBuf_r, 1'b0};
          txLeft_r  <= `UAB_FRAME_BITS;
        end
      end else if (txActive_r) begin
        if (txCnt_r == 24'h0) begin
          txShift_r <= {1'b1, txShift_r[13:1]};
          txLeft_r  <= txLeft_r - 4'h1;
          txCnt_r   <= bitCycles - 24'h1;
          if (txEnd) txActive_r <= 1'b0;
        end else begin
          txCnt_r <= txCnt_r - 24'h1;
        end
      end
    end
  end

  assign link.unitTx = txActive_r ? txShift_r[0] : 1'b1;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_comb begin
    rdMux = 32'h0;
    case (avs_address)
      `UAB_OFS_RXDATA: rdMux[7:0] = rxData_r;
      `UAB_OFS_BAUD_CONTROL_REG: begin
        rdMux[`UAB_BIT_ABEN]   = abEn_r;
        rdMux[`UAB_BIT_WOBE]   = wobe_r;
        rdMux[`UAB_BIT_WIDE]   = wide_r;
        rdMux[`UAB_BIT_RXIDLE] = (rxState_r == uab_pkg::UAB_RX_IDLE);
      end
      `UAB_OFS_TXSTAT: begin
        rdMux[`UAB_BIT_TXBE]  = ~txFull_r;
        rdMux[`UAB_BIT_SRE]   = ~txActive_r; // see RL21
        rdMux[`UAB_BIT_HS]    = hs_r;
        rdMux[`UAB_BIT_SEND_BREAK_REQUEST] = send_break_request_r;
        rdMux[`UAB_BIT_TRANSMIT_ENABLE]  = transmit_enable_r;
      end
      `UAB_OFS_RXSTAT: begin
        rdMux[`UAB_BIT_RXFLAG] = rxFlag_r;
        rdMux[`UAB_BIT_FRAMING_ERROR]   = framing_error_r;
      end
      `UAB_OFS_DIVLO: rdMux[7:0] = divLo_r;
      `UAB_OFS_DIVHI: rdMux[7:0] = divHi_r;
      default:        rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (ce && (avs_read | avs_write) && !ack_r) begin
      avs_readdata <= rdMux;
    end
  end

endmodule : uab_serial_unit

// file: pkg/uab_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the autobaud,
  wake and break serial unit. Assumes byte addressing on the register bus.
*/
`ifndef UAB_CFG_SVH
`define UAB_CFG_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define UAB_OFS_RXDATA   5'h00
`define UAB_OFS_TXDATA   5'h04
`define UAB_OFS_BAUD_CONTROL_REG  5'h08
`define UAB_OFS_TXSTAT   5'h0C
`define UAB_OFS_RXSTAT   5'h10
`define UAB_OFS_DIVLO    5'h14
`define UAB_OFS_DIVHI    5'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define UAB_BIT_ABEN     0
`define UAB_BIT_WOBE     1
`define UAB_BIT_WIDE     3
`define UAB_BIT_RXIDLE   6
`define UAB_BIT_TXBE     0
`define UAB_BIT_SRE      1
`define UAB_BIT_HS       2
`define UAB_BIT_SEND_BREAK_REQUEST    3
`define UAB_BIT_TRANSMIT_ENABLE     5
`define UAB_BIT_RXFLAG   0
`define UAB_BIT_FRAMING_ERROR     2

// ------------------------------------------------------------
// Reset values and timing counts
// ------------------------------------------------------------
`define UAB_RST_DIV      8'h00
`define UAB_PRE_SLOW     8'h40
`define UAB_PRE_MID      8'h10
`define UAB_PRE_FAST     8'h04
`define UAB_ABD_RATIO    4'h8
`define UAB_ABD_START    16'h0001
`define UAB_ABD_RISES    3'h4
`define UAB_FRAME_BITS   4'hA
`define UAB_BREAK_ZEROS  4'hC
`define UAB_NODE_ZEROS   5'h0D

`endif

// file: pkg/uab_link_if.sv
/*
  Serial link between the serial unit and the remote node.
  Assumes both lines idle high; the bench may add line delay.
*/
interface uab_link_if;
  logic unitTx;
  logic nodeTx;

  modport unit (output unitTx, input nodeTx);
  modport node (output nodeTx, input unitTx);
endinterface : uab_link_if

// file: pkg/uab_pkg.sv
/*
  Types of the serial link; the receiver states are shared by both ends.
  Assumes uab_cfg.svh supplies the numeric constants.
*/
package uab_pkg;

  // Receiver states, Gray along idle-start-data-stop-hold
  typedef enum logic [2:0] {
    UAB_RX_IDLE  = 3'h0,
    UAB_RX_START = 3'h1,
    UAB_RX_DATA  = 3'h3,
    UAB_RX_STOP  = 3'h2,
    UAB_RX_HOLD  = 3'h6
  } uab_rx_state_t;

  // Baud measurement states
  typedef enum logic [1:0] {
    UAB_AB_OFF    = 2'h0,
    UAB_AB_WSTART = 2'h1,
    UAB_AB_WRISE  = 2'h3,
    UAB_AB_COUNT  = 2'h2
  } uab_ab_state_t;

endpackage : uab_pkg

// file: verification/uab_link_monitor.sv
/*
  Checker of the serial link: bit grid, break length and stop gaps on both lines.
  Assumes both ends run one bit time of BIT core_clk cycles.
*/
module uab_link_monitor #(
  parameter int BIT = 136
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic unitTx,
  input wire logic nodeTx
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Run lengths of low and high levels
  // ------------------------------------------------------------
  logic [15:0] uLow_r;
  logic [15:0] uHigh_r;
  logic [15:0] nLow_r;
  logic [15:0] nHigh_r;

  // High counters saturate so that idle time never wraps into a short gap
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      uLow_r  <= 16'h0000;
      uHigh_r <= 16'hFFFF;
    end else begin
      uLow_r  <= unitTx ? 16'h0000 : uLow_r + 16'h0001;
      uHigh_r <= !unitTx ? 16'h0000 : uHigh_r + {15'h0, ~&uHigh_r};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nLow_r  <= 16'h0000;
      nHigh_r <= 16'hFFFF;
    end else begin
      nLow_r  <= nodeTx ? 16'h0000 : nLow_r + 16'h0001;
      nHigh_r <= !nodeTx ? 16'h0000 : nHigh_r + {15'h0, ~&nHigh_r};
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_unitBreakEnd;
    $rose(unitTx) && uLow_r == 13 * BIT;
  endsequence

  sequence s_stopHeld;
    unitTx [*8];
  endsequence

  chk_lines_idle_reset: assert property ($fell(rst) |-> unitTx && nodeTx)
    else $error("link not idle high after reset");
  chk_unit_bit_grid: assert property ($rose(unitTx) |-> uLow_r % BIT == 0)
    else $error("unit low run off the bit grid");
  chk_unit_break_len: assert property ($rose(unitTx) && uLow_r > 9 * BIT |-> uLow_r == 13 * BIT)
    else $error("unit break low time wrong");
  chk_break_stop_bit: assert property (s_unitBreakEnd |-> s_stopHeld)
    else $error("no stop bit after break");
  chk_unit_stop_gap: assert property ($fell(unitTx) |-> uHigh_r >= BIT)
    else $error("unit start without full stop bit");
  chk_node_bit_grid: assert property ($rose(nodeTx) |-> nLow_r % BIT == 0)
    else $error("node low run off the bit grid");
  chk_node_stop_gap: assert property ($fell(nodeTx) |-> nHigh_r >= BIT)
    else $error("node start without full stop bit");
  chk_node_wake_len: assert property ($rose(nodeTx) && nLow_r > 9 * BIT |-> nLow_r >= 13 * BIT && nLow_r <= 14 * BIT)
    else $error("node wake break length wrong");
endmodule : uab_link_monitor

// file: verification/uart_autobaud_wake_break_tb_top.sv
/*
  Testbench: serial unit and remote node joined by the link interface.
  Assumes a link bit time of 136 clocks on both ends.
*/
`include "uab_cfg.svh"

module uart_autobaud_wake_break_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk      = 1'b0;
  logic        rst           = 1'b1;
  logic        sleepMode     = 1'b0;
  logic [4:0]  avs_address   = 5'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rxEventIrq;
  logic        sendValid     = 1'b0;
  logic        sendBreak     = 1'b0;
  logic [7:0]  sendData      = 8'h00;
  logic        sendReady;
  logic        rcvValid;
  logic [7:0]  rcvData;
  logic        rcvFramingErr;
  logic [8:0]  rxQ[$];
  int          numErrors     = 0;
  int          nTests        = 0;

  always #5 core_clk = ~core_clk;

  uab_link_if link();
  uab_serial_unit u_uab_serial_unit (.core_clk(core_clk), .rst(rst), .ce(1'b1), .sleepMode(sleepMode),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxEventIrq(rxEventIrq), .link(link));
  uab_remote_node u_uab_remote_node (.core_clk(core_clk), .rst(rst), .ce(1'b1), .bitCycles(24'h000088),
    .sendValid(sendValid), .sendBreak(sendBreak), .sendData(sendData), .sendReady(sendReady),
    .rcvValid(rcvValid), .rcvData(rcvData), .rcvFramingErr(rcvFramingErr), .link(link));
  uab_link_monitor #(.BIT(136)) u_uab_link_monitor (.core_clk(core_clk), .rst(rst),
    .unitTx(link.unitTx), .nodeTx(link.nodeTx));

  always @(posedge core_clk) if (rcvValid === 1'b1) rxQ.push_back({rcvFramingErr, rcvData});

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait step; sampling mid-cycle keeps clear of edge races
  task automatic tick(inout int n, input int lim);
    @(negedge core_clk);
    n++;
    if (n == lim) numErrors++;
  endtask : tick

  task automatic busXfer(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : busXfer

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    busXfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    busXfer(1'b1, a, d, q);
  endtask : wr

  task automatic nodeStart(input logic brk, input logic [7:0] data);
    @(posedge core_clk);
    sendValid <= 1'b1;
    sendBreak <= brk;
    sendData  <= data;
    @(posedge core_clk);
    while (sendReady !== 1'b1) @(posedge core_clk);
    sendValid <= 1'b0;
  endtask : nodeStart

  task automatic nodeDone();
    int n;
    n = 0;
    tick(n, 4000);
    while (sendReady !== 1'b1 && n < 4000) tick(n, 4000);
  endtask : nodeDone

  task automatic waitIrq();
    int n;
    n = 0;
    while (rxEventIrq !== 1'b1 && n < 4000) tick(n, 4000);
  endtask : waitIrq

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    int n;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(`UAB_OFS_BAUD_CONTROL_REG, 32'h40);
    rd(`UAB_OFS_TXSTAT, 32'h3);
    rd(`UAB_OFS_RXSTAT, 32'h0);
    rd(`UAB_OFS_DIVLO, 32'h0);
    rd(`UAB_OFS_DIVHI, 32'h0);
    rd(5'h1C, 32'h0);
    $display("test reset values done");
    // Wide divisor, high speed: 4 * (33 + 1) = 136 clocks a bit
    wr(`UAB_OFS_BAUD_CONTROL_REG, 32'h8);
    wr(`UAB_OFS_TXSTAT, 32'h24);
    wr(`UAB_OFS_DIVLO, 32'h21);
    nodeStart(1'b1, 8'h00);
    waitIrq();
    rd(`UAB_OFS_RXSTAT, 32'h5);
    rd(`UAB_OFS_RXDATA, 32'h0);
    nodeDone();
    nodeStart(1'b0, 8'hA5);
    waitIrq();
    rd(`UAB_OFS_RXSTAT, 32'h1);
    rd(`UAB_OFS_RXDATA, 32'hA5);
    rd(`UAB_OFS_RXSTAT, 32'h0);
    $display("test receive and break receive done");
    wr(`UAB_OFS_TXSTAT, 32'h2C);
    wr(`UAB_OFS_TXDATA, 32'hFF);
    wr(`UAB_OFS_TXDATA, 32'h55);
    rd(`UAB_OFS_TXSTAT, 32'h2C);
    n = 0;
    while (rxQ.size() < 2 && n < 6000) tick(n, 6000);
    check({23'h0, rxQ[0]}, 32'h100);
    check({23'h0, rxQ[1]}, 32'h55);
    repeat (272) @(posedge core_clk);
    rd(`UAB_OFS_TXSTAT, 32'h27);
    $display("test break transmit done");
    rd(`UAB_OFS_BAUD_CONTROL_REG, 32'h48);
    wr(`UAB_OFS_BAUD_CONTROL_REG, 32'hA);
    sleepMode <= 1'b1;
    nodeStart(1'b1, 8'h00);
    waitIrq();
    check({31'h0, link.nodeTx}, 32'h0);
    nodeDone();
    @(posedge core_clk);
    sleepMode <= 1'b0;
    rd(`UAB_OFS_BAUD_CONTROL_REG, 32'h48);
    rd(`UAB_OFS_RXSTAT, 32'h1);
    rd(`UAB_OFS_RXDATA, 32'hA5);
    rd(`UAB_OFS_RXSTAT, 32'h0);
    check({31'h0, rxEventIrq}, 32'h0);
    $display("test wake on break done");
    // Narrow, normal speed: count ticks every 512 clocks over 8 * 136
    wr(`UAB_OFS_TXSTAT, 32'h20);
    wr(`UAB_OFS_BAUD_CONTROL_REG, 32'h3);
    nodeStart(1'b1, 8'h00);
    nodeDone();
    rd(`UAB_OFS_BAUD_CONTROL_REG, 32'h41);
    rd(`UAB_OFS_RXDATA, 32'hA5);
    nodeStart(1'b0, 8'h55);
    waitIrq();
    rd(`UAB_OFS_BAUD_CONTROL_REG, 32'h40);
    rd(`UAB_OFS_DIVLO, 32'h3);
    rd(`UAB_OFS_DIVHI, 32'h0);
    rd(`UAB_OFS_RXSTAT, 32'h1);
    rd(`UAB_OFS_RXDATA, 32'hA5);
    rd(`UAB_OFS_RXSTAT, 32'h0);
    $display("test autobaud after break done");
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    numErrors++;
    finish_test();
  end
endmodule : uart_autobaud_wake_break_tb_top
